// ---- rtl/eeprom_host.sv ----
module eeprom_host import eeprom_host_pkg::*; #(
    parameter int unsigned LOAD_GAP_CYC = BLC_CYC,
    parameter int unsigned POLL_MAX_CYC = WC_MAX_CYC
) (
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic              req_valid,
    input  wire logic              req_write,
    input  wire logic              req_last,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    output logic                   req_ready,
    output logic                   rsp_valid,
    output logic      [DATA_W-1:0] rsp_rdata,
    output logic                   wr_done,
    output logic                   poll_timeout,
    output logic                   busy,
    input  wire logic              supply_ok,
    output logic      [ADDR_W-1:0] mem_addr,
    output logic      [DATA_W-1:0] mem_dout,
    output logic                   mem_dout_oe_n,
    input  wire logic [DATA_W-1:0] mem_din,
    output logic                   mem_ce_n,
    output logic                   mem_oe_n,
    output logic                   mem_we_n
);

    // ==========================================================
    // Elaboration checks
    localparam int unsigned WIN_LIMIT = LOAD_GAP_CYC - SETUP_CYC - 2;

    generate
        if (LOAD_GAP_CYC < SETUP_CYC + 4 || LOAD_GAP_CYC > 65535) begin : g_bad_gap
            $error("LOAD_GAP_CYC out of range");
        end
        if (POLL_MAX_CYC < 1 || POLL_MAX_CYC > 16777215) begin : g_bad_poll
            $error("POLL_MAX_CYC out of range");
        end
    endgenerate

    // ==========================================================
    // Input synchronisers
    logic [DATA_W-1:0] din_s;
    logic              supply_s;

    pin_sync #(.WIDTH(DATA_W)) u_din_sync (
        .clk     (clk),
        .resetn  (resetn),
        .pin_in  (mem_din),
        .level_q (din_s)
    );

    pin_sync #(.WIDTH(1)) u_supply_sync (
        .clk     (clk),
        .resetn  (resetn),
        .pin_in  (supply_ok),
        .level_q (supply_s)
    );

    // ==========================================================
    // State
    state_t            state_q,     state_d;
    logic [15:0]       cnt_q,       cnt_d;
    logic [15:0]       win_q,       win_d;
    logic [23:0]       poll_q,      poll_d;
    logic [5:0]        bytes_q,     bytes_d;
    logic              close_q,     close_d;
    logic              polling_q,   polling_d;
    logic [ADDR_W-1:0] last_addr_q, last_addr_d;
    logic [DATA_W-1:0] last_data_q, last_data_d;
    logic [DATA_W-1:0] rd_data_q,   rd_data_d;
    logic              pend_q,      pend_d;
    logic              pend_wr_q,   pend_wr_d;
    logic [ADDR_W-1:0] pend_addr_q, pend_addr_d;
    logic [DATA_W-1:0] pend_data_q, pend_data_d;
    logic              ready_d;
    logic              rsp_d;
    logic              done_d;
    logic              tmo_d;
    logic [ADDR_W-1:0] addr_d;
    logic [DATA_W-1:0] dout_d;

    logic              take;
    logic              start;
    logic              src_wr;
    logic [ADDR_W-1:0] src_addr;
    logic [DATA_W-1:0] src_data;
    logic              same_page;

    always_comb begin
        take      = req_valid && req_ready;
        start     = pend_q ? supply_s : take;
        src_wr    = pend_q ? pend_wr_q : req_write;
        src_addr  = pend_q ? pend_addr_q : req_addr;
        src_data  = pend_q ? pend_data_q : req_wdata;
        same_page = req_addr[PAGE_MSB:PAGE_LSB] == last_addr_q[PAGE_MSB:PAGE_LSB];
    end

    // ==========================================================
    // Sequencer
    always_comb begin
        state_d     = state_q;
        cnt_d       = cnt_q + 16'h0001;
        win_d       = (win_q < 16'(LOAD_GAP_CYC)) ? win_q + 16'h0001 : win_q;
        poll_d      = polling_q ? poll_q + 24'h000001 : poll_q;
        bytes_d     = bytes_q;
        close_d     = close_q;
        polling_d   = polling_q;
        last_addr_d = last_addr_q;
        last_data_d = last_data_q;
        rd_data_d   = rd_data_q;
        pend_d      = pend_q;
        pend_wr_d   = pend_wr_q;
        pend_addr_d = pend_addr_q;
        pend_data_d = pend_data_q;
        addr_d      = mem_addr;
        dout_d      = mem_dout;
        rsp_d       = 1'b0;
        done_d      = 1'b0;
        tmo_d       = 1'b0;
        case (state_q)
            ST_IDLE: begin
                // Nothing starts while the supply is low, matching the part's own lockout.
                if (start) begin
                    pend_d = 1'b0;
                    addr_d = src_addr;
                    cnt_d  = 16'h0000;
                    if (src_wr) begin
                        dout_d      = src_data;
                        last_addr_d = src_addr;
                        last_data_d = src_data;
                        bytes_d     = 6'h01;
                        close_d     = pend_q ? 1'b0 : req_last;
                        state_d     = ST_WR_SETUP;
                    end else begin
                        polling_d = 1'b0;
                        state_d   = ST_RD_SETUP;
                    end
                end
            end
            ST_WR_SETUP: begin
                // Output enable has been high for its setup time before the strobe falls.
                if (cnt_q >= 16'(SETUP_CYC - 1)) begin
                    cnt_d   = 16'h0000;
                    win_d   = 16'h0000;
                    state_d = ST_WR_PULSE;
                end
            end
            ST_WR_PULSE: begin
                if (cnt_q >= 16'(WP_CYC - 1)) begin
                    cnt_d   = 16'h0000;
                    state_d = ST_WR_HOLD;
                end
            end
            ST_WR_HOLD: begin
                // Address and data stay put past the strobe rise so both latches see them.
                if (cnt_q >= 16'(HOLD_CYC - 1)) begin
                    state_d = ST_PAGE_OPEN;
                end
            end
            ST_PAGE_OPEN: begin
                if (take) begin
                    if (req_write && same_page && bytes_q < 6'(PAGE_BYTES)) begin
                        addr_d      = req_addr;
                        dout_d      = req_wdata;
                        last_addr_d = req_addr;
                        last_data_d = req_wdata;
                        bytes_d     = bytes_q + 6'h01;
                        close_d     = req_last;
                        cnt_d       = 16'h0000;
                        state_d     = ST_WR_SETUP;
                    end else begin
                        // Foreign requests wait until polling of the page ends in done or timeout.
                        pend_d      = 1'b1;
                        pend_wr_d   = req_write;
                        pend_addr_d = req_addr;
                        pend_data_d = req_wdata;
                        close_d     = 1'b1;
                    end
                end else if (win_q >= 16'(LOAD_GAP_CYC)) begin
                    // Polling only after the load window is surely over keeps reads
                    // from landing while the part still takes bytes.
                    addr_d    = last_addr_q;
                    polling_d = 1'b1;
                    poll_d    = 24'h000000;
                    cnt_d     = 16'h0000;
                    state_d   = ST_RD_SETUP;
                end
            end
            ST_RD_SETUP: begin
                cnt_d   = 16'h0000;
                state_d = ST_RD_WAIT;
            end
            ST_RD_WAIT: begin
                if (cnt_q >= 16'(RD_CYC - 1)) begin
                    rd_data_d = din_s;
                    cnt_d     = 16'h0000;
                    state_d   = ST_RD_END;
                end
            end
            ST_RD_END: begin
                // The gap lets the part release the bus before anything drives it.
                if (cnt_q >= 16'(HZ_CYC - 1)) begin
                    cnt_d = 16'h0000;
                    if (!polling_q) begin
                        rsp_d   = 1'b1;
                        state_d = ST_IDLE;
                    end else if (rd_data_q[TOP_BIT] == last_data_q[TOP_BIT]) begin
                        polling_d = 1'b0;
                        done_d    = 1'b1;
                        state_d   = ST_RECOVER;
                    end else if (poll_q >= 24'(POLL_MAX_CYC)) begin
                        polling_d = 1'b0;
                        tmo_d     = 1'b1;
                        state_d   = ST_IDLE;
                    end else begin
                        state_d = ST_RD_SETUP;
                    end
                end
            end
            ST_RECOVER: begin
                if (cnt_q >= 16'(DW_CYC - 1)) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        ready_d = supply_s && !pend_d && ((state_d == ST_IDLE)
                  || (state_d == ST_PAGE_OPEN && !close_d && win_d < 16'(WIN_LIMIT)));
    end

    // ==========================================================
    // Registers; pins idle in the inhibit state from reset on.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q       <= ST_IDLE;
            cnt_q         <= 16'h0000;
            win_q         <= 16'h0000;
            poll_q        <= 24'h000000;
            bytes_q       <= 6'h00;
            close_q       <= 1'b0;
            polling_q     <= 1'b0;
            last_addr_q   <= '0;
            last_data_q   <= '0;
            rd_data_q     <= '0;
            pend_q        <= 1'b0;
            pend_wr_q     <= 1'b0;
            pend_addr_q   <= '0;
            pend_data_q   <= '0;
            req_ready     <= 1'b0;
            rsp_valid     <= 1'b0;
            rsp_rdata     <= '0;
            wr_done       <= 1'b0;
            poll_timeout  <= 1'b0;
            busy          <= 1'b0;
            mem_addr      <= '0;
            mem_dout      <= '0;
            mem_dout_oe_n <= 1'b1;
            mem_ce_n      <= 1'b1;
            mem_oe_n      <= 1'b1;
            mem_we_n      <= 1'b1;
        end else begin
            state_q       <= state_d;
            cnt_q         <= cnt_d;
            win_q         <= win_d;
            poll_q        <= poll_d;
            bytes_q       <= bytes_d;
            close_q       <= close_d;
            polling_q     <= polling_d;
            last_addr_q   <= last_addr_d;
            last_data_q   <= last_data_d;
            rd_data_q     <= rd_data_d;
            pend_q        <= pend_d;
            pend_wr_q     <= pend_wr_d;
            pend_addr_q   <= pend_addr_d;
            pend_data_q   <= pend_data_d;
            req_ready     <= ready_d;
            rsp_valid     <= rsp_d;
            rsp_rdata     <= rsp_d ? rd_data_q : rsp_rdata;
            wr_done       <= done_d;
            poll_timeout  <= tmo_d;
            busy          <= (state_d != ST_IDLE) || pend_d;
            mem_addr      <= addr_d;
            mem_dout      <= dout_d;
            // Select follows the access itself, so an outer decoder may gate it too.
            mem_ce_n      <= !(state_d inside {ST_WR_SETUP, ST_WR_PULSE, ST_WR_HOLD,
                                               ST_RD_SETUP, ST_RD_WAIT});
            mem_oe_n      <= !(state_d inside {ST_RD_SETUP, ST_RD_WAIT});
            mem_we_n      <= !(state_d == ST_WR_PULSE);
            mem_dout_oe_n <= !(state_d inside {ST_WR_SETUP, ST_WR_PULSE, ST_WR_HOLD});
        end
    end

endmodule : eeprom_host

// ---- rtl/eeprom_host_pkg.sv ----
// Overview of operation
// - A write needs chip select and write strobe low with output enable high.
// - The host keeps the page select bits unchanged over one page.
// - Any byte write may grow into a page of up to 31 more bytes.
// - The host starts each further byte load within 100 us of the last.
// - Output enable low, strobe high or select high inhibit writes.
// - Chip select comes from address decode; enable and strobe are shared. This host drives select from its access states instead.
package eeprom_host_pkg;

    // ==========================================================
    // Geometry
    localparam int unsigned ADDR_W      = 13;
    localparam int unsigned DATA_W      = 8;
    localparam int unsigned PAGE_BYTES  = 32;
    localparam int unsigned PAGE_LSB    = 5;
    localparam int unsigned PAGE_MSB    = 12;
    localparam int unsigned TOP_BIT     = 7;

    // ==========================================================
    // Timing figures as printed
    localparam int unsigned CLK_MHZ     = 125;
    localparam int unsigned T_OES_NS    = 10;
    localparam int unsigned T_WP_NS     = 100;
    localparam int unsigned T_AH_NS     = 50;
    localparam int unsigned T_OHZ_NS    = 50;
    localparam int unsigned T_ACC_NS    = 180;
    localparam int unsigned T_BLC_US    = 100;
    localparam int unsigned T_DW_US     = 10;
    localparam int unsigned T_WC_MS     = 5;

    // ==========================================================
    // Cycle counts; nanosecond times round up, microsecond and millisecond times convert exactly.
    localparam int unsigned SETUP_CYC   = (T_OES_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned WP_CYC      = (T_WP_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned HOLD_CYC    = (T_AH_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned HZ_CYC      = (T_OHZ_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned SYNC_LAT    = 4;
    localparam int unsigned RD_CYC      = (T_ACC_NS * CLK_MHZ + 999) / 1000 + SYNC_LAT;
    localparam int unsigned DW_CYC      = T_DW_US * CLK_MHZ;
    localparam int unsigned BLC_CYC     = T_BLC_US * CLK_MHZ;
    localparam int unsigned WC_MAX_CYC  = T_WC_MS * 1000 * CLK_MHZ;

    // ==========================================================
    // Controller states, Gray coded along the write and poll path
    typedef enum logic [3:0] {
        ST_IDLE      = 4'h0,
        ST_WR_SETUP  = 4'h1,
        ST_WR_PULSE  = 4'h3,
        ST_WR_HOLD   = 4'h2,
        ST_PAGE_OPEN = 4'h6,
        ST_RD_SETUP  = 4'h7,
        ST_RD_WAIT   = 4'h5,
        ST_RD_END    = 4'h4,
        ST_RECOVER   = 4'hC
    } state_t;

endpackage : eeprom_host_pkg

// ---- rtl/pin_sync.sv ----
module pin_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_q
);

    // ==========================================================
    // Three stages per bit; a change counts only once stages two and three agree.
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] level_d;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_comb begin
                level_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : level_q[i];
            end
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    s1_q[i]    <= 1'b0;
                    s2_q[i]    <= 1'b0;
                    s3_q[i]    <= 1'b0;
                    level_q[i] <= 1'b0;
                end else begin
                    s1_q[i]    <= pin_in[i];
                    s2_q[i]    <= s1_q[i];
                    s3_q[i]    <= s2_q[i];
                    level_q[i] <= level_d[i];
                end
            end
        end
    endgenerate

endmodule : pin_sync

// ---- sim/eeprom_host_properties.sv ----
// ==========================================================
// Pin protocol checker
module eeprom_host_properties import eeprom_host_pkg::*; #(
    parameter int unsigned LOAD_GAP_CYC = 40
) (
    input wire logic              clk,
    input wire logic              resetn,
    input wire logic              supply_ok,
    input wire logic              req_ready,
    input wire logic              rsp_valid,
    input wire logic              wr_done,
    input wire logic              poll_timeout,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic [DATA_W-1:0] mem_dout,
    input wire logic              mem_dout_oe_n,
    input wire logic              mem_ce_n,
    input wire logic              mem_oe_n,
    input wire logic              mem_we_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    logic        we_q;
    logic        open_q;
    logic        open_d;
    logic        we_fall;
    logic [31:0] gap_q;
    logic [31:0] gap_d;
    logic [7:0]  page_q;
    logic [7:0]  page_d;

    // The gap counter saturates so a long idle spell never wraps into a short one.
    always_comb begin
        we_fall = we_q & ~mem_we_n;
        open_d  = open_q;
        page_d  = page_q;
        gap_d   = (gap_q == 32'hFFFFFFFF) ? gap_q : gap_q + 32'h1;
        if (we_fall) begin
            open_d = 1'b1;
            gap_d  = 32'h0;
            page_d = mem_addr[PAGE_MSB:PAGE_LSB];
        end else if (!mem_oe_n) begin
            open_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            we_q   <= 1'b1;
            open_q <= 1'b0;
            gap_q  <= 32'h0;
            page_q <= 8'h0;
        end else begin
            we_q   <= mem_we_n;
            open_q <= open_d;
            gap_q  <= gap_d;
            page_q <= page_d;
        end
    end

    AST_WR_MODE: assert property (!mem_we_n |-> !mem_ce_n && mem_oe_n)
        else $error("write strobe low outside a write combination");
    AST_RD_MODE: assert property (!mem_oe_n |-> mem_we_n && mem_dout_oe_n)
        else $error("output enable low during a write or while driving data");
    AST_LATCH_STABLE: assert property (!mem_we_n |-> $stable(mem_addr)
        && $stable(mem_dout) && !mem_dout_oe_n) else $error("address or data moved in strobe");
    AST_WE_WIDTH: assert property ($fell(mem_we_n) |-> !mem_we_n [*8])
        else $error("write strobe pulse too short");
    AST_PAGE_SAME: assert property (we_fall && open_q |->
        mem_addr[PAGE_MSB:PAGE_LSB] == page_q) else $error("page bits changed in a page");
    AST_GAP_EXTEND: assert property (we_fall && open_q |-> gap_q < LOAD_GAP_CYC)
        else $error("byte load started after the load window");
    AST_GAP_POLL: assert property ($fell(mem_oe_n) && open_q |->
        gap_q >= LOAD_GAP_CYC - 1) else $error("poll read inside the load window");
    AST_SUPPLY: assert property (!supply_ok [*8] |-> !req_ready)
        else $error("request accepted with supply low");
    AST_RSP_PULSE: assert property (rsp_valid |=> !rsp_valid)
        else $error("read response longer than one cycle");
    AST_DONE_PULSE: assert property (wr_done |-> !poll_timeout ##1 !wr_done)
        else $error("write done not a lone pulse");
endmodule : eeprom_host_properties

bind eeprom_host eeprom_host_properties #(.LOAD_GAP_CYC(LOAD_GAP_CYC)) eeprom_host_properties_inst (
    .clk(clk), .resetn(resetn), .supply_ok(supply_ok), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .wr_done(wr_done), .poll_timeout(poll_timeout),
    .mem_addr(mem_addr), .mem_dout(mem_dout), .mem_dout_oe_n(mem_dout_oe_n),
    .mem_ce_n(mem_ce_n), .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n)
);

// ---- sim/eeprom_model.sv ----
// ==========================================================
// Behavioural parallel memory device
module eeprom_model import eeprom_host_pkg::*; #(
    parameter int unsigned LOAD_GAP_CYC = 40,
    parameter int unsigned PROG_CYC     = 300
) (
    input wire logic              clk,
    input wire logic              supply_ok,
    input wire logic              slow,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] host_data,
    input wire logic              host_oe_n,
    input wire logic              ce_n,
    input wire logic              oe_n,
    input wire logic              we_n,
    output logic      [DATA_W-1:0] pin_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DATA_W-1:0]     mem [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0]     pbuf [0:PAGE_BYTES-1];
    logic [PAGE_BYTES-1:0] pvalid = '0;
    logic [ADDR_W-1:0]     lat_addr = '0;
    logic [DATA_W-1:0]     last_data = '0;
    logic [DATA_W-1:0]     prev = '0;
    logic                  wr_q = 1'b0;
    logic                  loading = 1'b0;
    logic                  programming = 1'b0;
    logic                  wr_on;
    int                    gap = 0;
    int                    prog = 0;

    assign wr_on = !ce_n && !we_n && oe_n && supply_ok;
    initial for (int i = 0; i < (1 << ADDR_W); i++) mem[i] = 8'hFF;

    always @(posedge clk) begin
        wr_q <= wr_on;
        prev <= pin_data;
        if (!programming) begin
            if (loading) gap <= gap + 1;
            if (wr_on && !wr_q) begin
                lat_addr <= addr;
                loading  <= 1'b1;
                gap      <= 0;
            end else if (!wr_on && wr_q) begin
                pbuf[lat_addr[PAGE_LSB-1:0]]   <= host_data;
                pvalid[lat_addr[PAGE_LSB-1:0]] <= 1'b1;
                last_data                      <= host_data;
            end else if (loading && gap >= LOAD_GAP_CYC) begin
                loading     <= 1'b0;
                programming <= 1'b1;
                prog        <= 0;
            end
        end else if (!slow) begin
            prog <= prog + 1;
            if (prog == PROG_CYC) begin
                programming <= 1'b0;
                pvalid      <= '0;
                for (int i = 0; i < PAGE_BYTES; i++) begin
                    if (pvalid[i]) mem[{lat_addr[PAGE_MSB:PAGE_LSB], PAGE_LSB'(i)}] <= pbuf[i];
                end
            end
        end
    end

    // Released lines show the inverse of their last level so stale data never reads as good.
    always_comb begin
        if (!host_oe_n) begin
            pin_data = host_data;
        end else if (!ce_n && !oe_n && supply_ok) begin
            pin_data = mem[addr];
            if (programming && addr == lat_addr) begin
                pin_data = {~last_data[TOP_BIT], last_data[TOP_BIT-1:0]};
            end
        end else begin
            pin_data = ~prev;
        end
    end
endmodule : eeprom_model

// ---- sim/tb_eeprom_host.sv ----
module tb_eeprom_host import eeprom_host_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned GAP = 40;
    logic              clk = 1'b0;
    logic              resetn = 1'b0;
    logic              supply_ok = 1'b1;
    logic              slow = 1'b0;
    logic              req_valid = 1'b0;
    logic              req_write = 1'b0;
    logic              req_last = 1'b0;
    logic [ADDR_W-1:0] req_addr = '0;
    logic [DATA_W-1:0] req_wdata = '0;
    logic [DATA_W-1:0] rsp_rdata, mem_dout, mem_din;
    logic [ADDR_W-1:0] mem_addr;
    logic              req_ready, rsp_valid, wr_done, poll_timeout, busy;
    logic              mem_dout_oe_n, mem_ce_n, mem_oe_n, mem_we_n;
    int                fails = 0;
    int                num_checks = 0;

    always #4 clk = ~clk;

    eeprom_host #(.LOAD_GAP_CYC(GAP), .POLL_MAX_CYC(2000)) eeprom_host_inst (
        .clk(clk), .resetn(resetn), .req_valid(req_valid), .req_write(req_write),
        .req_last(req_last), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .wr_done(wr_done), .poll_timeout(poll_timeout), .busy(busy), .supply_ok(supply_ok),
        .mem_addr(mem_addr), .mem_dout(mem_dout), .mem_dout_oe_n(mem_dout_oe_n),
        .mem_din(mem_din), .mem_ce_n(mem_ce_n), .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n));
    eeprom_model #(.LOAD_GAP_CYC(GAP)) eeprom_model_inst (
        .clk(clk), .supply_ok(supply_ok), .slow(slow), .addr(mem_addr), .host_data(mem_dout),
        .host_oe_n(mem_dout_oe_n), .ce_n(mem_ce_n), .oe_n(mem_oe_n), .we_n(mem_we_n),
        .pin_data(mem_din));

    // ==========================================================
    // Shared tasks
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wait_ev(input int which, input int lim);
        int   n;
        logic hit;
        n = 0;
        do begin
            @(negedge clk);
            n++;
            hit = (which == 0) ? wr_done : (which == 1) ? rsp_valid : poll_timeout;
        end while (hit !== 1'b1 && n < lim);
        if (hit !== 1'b1) begin
            fails++;
            $display("[FAIL] %0t wait ran out", $time);
            end_sim();
        end
    endtask : wait_ev

    task automatic send(input logic w, input logic l, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d);
        int n;
        @(posedge clk);
        #1;
        req_valid = 1'b1;
        req_write = w;
        req_last  = l;
        req_addr  = a;
        req_wdata = d;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (req_ready !== 1'b1 && n < 20000);
        if (req_ready !== 1'b1) begin
            fails++;
            $display("[FAIL] %0t request never taken", $time);
            end_sim();
        end
        @(posedge clk);
        #1;
        req_valid = 1'b0;
    endtask : send

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        send(1'b0, 1'b0, a, '0);
        wait_ev(1, 5000);
        chk(rsp_rdata, e);
    endtask : rd

    // ==========================================================
    // Scenarios
    task automatic s_byte;
        send(1'b1, 1'b1, 13'h0123, 8'hA5);
        wait_ev(0, 5000);
        chk(DATA_W'(busy), 8'h01);
        rd(13'h0123, 8'hA5);
        rd(13'h0124, 8'hFF);
        chk(DATA_W'(busy), 8'h00);
    endtask : s_byte

    task automatic s_page;
        for (int i = 0; i < PAGE_BYTES; i++) begin
            send(1'b1, i == PAGE_BYTES - 1, ADDR_W'(13'h1FE0 + i),
                 DATA_W'(i * 37 + 1));
        end
        wait_ev(0, 5000);
        for (int i = 0; i < PAGE_BYTES; i++) begin
            rd(ADDR_W'(13'h1FE0 + i), DATA_W'(i * 37 + 1));
        end
    endtask : s_page

    task automatic s_park;
        send(1'b1, 1'b0, 13'h0040, 8'h3C);
        send(1'b1, 1'b0, 13'h0060, 8'hC3);
        rd(13'h0040, 8'h3C);
        rd(13'h0060, 8'hC3);
    endtask : s_park

    task automatic s_supply;
        int lows;
        lows = 0;
        @(posedge clk);
        #1;
        supply_ok = 1'b0;
        repeat (10) @(posedge clk);
        #1;
        req_valid = 1'b1;
        req_write = 1'b1;
        req_last  = 1'b1;
        req_addr  = 13'h0050;
        req_wdata = 8'h11;
        repeat (20) begin
            @(negedge clk);
            lows += (mem_we_n !== 1'b1 || req_ready !== 1'b0) ? 1 : 0;
        end
        chk(DATA_W'(lows), 8'h00);
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        supply_ok = 1'b1;
        rd(13'h0050, 8'hFF);
    endtask : s_supply

    task automatic s_timeout;
        slow = 1'b1;
        send(1'b1, 1'b1, 13'h0777, 8'h5A);
        wait_ev(2, 5000);
        slow = 1'b0;
        repeat (400) @(posedge clk);
        rd(13'h0777, 8'h5A);
    endtask : s_timeout

    initial begin
        repeat (6) @(posedge clk);
        #1;
        resetn = 1'b1;
        s_byte();
        s_page();
        s_park();
        s_supply();
        s_timeout();
        end_sim();
    end
endmodule : tb_eeprom_host
